/* File: hw/fxu_defines.svh */
`ifndef FXU_DEFINES_SVH
`define FXU_DEFINES_SVH
// register byte offsets
`define FXU_OFF_CTRL 12'h000
`define FXU_OFF_XER 12'h004
`define FXU_OFF_MQ 12'h008
`define FXU_OFF_CR 12'h00c
`define FXU_OFF_STAT 12'h010
`define FXU_GPR_WIN 5'h01
`define FXU_GPR_WIN_HI 11:7
`define FXU_GPR_IDX 6:2
// reset values
`define FXU_CTRL_RST 32'h0000_0000
`define FXU_WORD_RST 32'h0000_0000
// control bits
`define FXU_CTRL_OLD 0
`define FXU_CTRL_HWUA 1
`define FXU_CTRL_MASK 32'h0000_0003
// exception register bits
`define FXU_XER_SO 31
`define FXU_XER_OV 30
`define FXU_XER_CA 29
`define FXU_XER_LEN 6:0
// instruction fields
`define FXU_F_RT 25:21
`define FXU_F_TO 25:21
`define FXU_F_BF 25:23
`define FXU_F_RA 20:16
`define FXU_F_RB 15:11
`define FXU_F_SI 15:0
`define FXU_F_RC 0
`define FXU_GPR0 5'h00
`define FXU_CR0 3'h0
`endif

/* File: hw/fxu_exec.sv */
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ns
`include "fxu_defines.svh"
module fxu_exec (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // issue port
  input wire logic iss_valid,
  input wire fxu_pkg::fxu_issue_t iss,
  output logic iss_ready,
  // storage port
  output logic mem_req,
  output fxu_pkg::fxu_mreq_t mem,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_fault,
  // exception and status
  output fxu_pkg::fxu_evt_t evt,
  output logic [31:0] cr
);
  logic [31:0] gpr_q [32];
  logic [31:0] xer_q;
  logic [31:0] mq_q;
  logic [31:0] ctrl_q;
  logic [31:0] cr_q;
  fxu_pkg::fxu_state_t st_q;
  fxu_pkg::fxu_issue_t op_q;
  fxu_pkg::fxu_mreq_t mem_q;
  fxu_pkg::fxu_evt_t evt_q;
  logic mem_req_q;
  logic [31:0] prdata_q;
  logic ack_q;
  logic err_q;

  // comparison flags {lt, gt, eq, ult, ugt}, bit 4 is trap field bit 4
  function automatic logic [4:0] cond5(input logic [31:0] x, input logic [31:0] y);
    cond5 = {$signed(x) < $signed(y), $signed(x) > $signed(y), x == y,
      x < y, x > y};
  endfunction

  function automatic logic [31:0] crput(input logic [31:0] c, input logic [2:0] f,
    input logic [3:0] n);
    logic [4:0] sh;
    sh = {f, 2'b00};
    crput = (c & ~(32'hf000_0000 >> sh)) | ({n, 28'h000_0000} >> sh);
  endfunction

  function automatic logic misal(input logic [1:0] a, input fxu_pkg::fxu_size_t s);
    misal = (s == fxu_pkg::fxu_sz_half && a[0]) ||
      (s == fxu_pkg::fxu_sz_word && a != 2'b00);
  endfunction

  // operand decode
  logic fire;
  logic [4:0] rt;
  logic [4:0] ra;
  logic [4:0] rb;
  logic [31:0] a;
  logic [31:0] s;
  logic [31:0] opb;
  logic [31:0] sxi;
  logic old;
  logic hwua;
  assign iss_ready = (st_q == fxu_pkg::fxu_st_idle);
  assign fire = ce & iss_valid & iss_ready;
  assign rt = iss.instr[`FXU_F_RT];
  assign ra = iss.instr[`FXU_F_RA];
  assign rb = iss.instr[`FXU_F_RB];
  assign a = gpr_q[ra];
  assign s = gpr_q[rt];
  assign sxi = {{16{iss.instr[15]}}, iss.instr[`FXU_F_SI]};
  assign old = ctrl_q[`FXU_CTRL_OLD];
  assign hwua = ctrl_q[`FXU_CTRL_HWUA];

  always_comb begin
    case (iss.src)
      fxu_pkg::fxu_src_si: opb = sxi;
      fxu_pkg::fxu_src_ui: opb = {16'h0000, iss.instr[`FXU_F_SI]};
      default: opb = gpr_q[rb];
    endcase
  end

  // alu
  logic [32:0] sum;
  logic [32:0] dif;
  logic [31:0] res;
  logic ov;
  logic ca;
  logic arith;
  logic alu_op;
  logic [4:0] cnd;
  logic so_now;
  assign sum = {1'b0, a} + {1'b0, opb};
  assign dif = {1'b0, a} + {1'b0, ~opb} + 33'h0_0000_0001;
  assign cnd = cond5(a, opb);
  assign arith = iss.op == fxu_pkg::fxu_op_add || iss.op == fxu_pkg::fxu_op_sub;
  assign alu_op = arith || iss.op == fxu_pkg::fxu_op_and ||
    iss.op == fxu_pkg::fxu_op_or || iss.op == fxu_pkg::fxu_op_xor ||
    iss.op == fxu_pkg::fxu_op_nor;

  always_comb begin
    res = sum[31:0];
    ca = 1'b0;
    ov = 1'b0;
    case (iss.op)
      fxu_pkg::fxu_op_add: begin
        res = sum[31:0];
        ca = sum[32];
        ov = (a[31] == opb[31]) && (sum[31] != a[31]);
      end
      fxu_pkg::fxu_op_sub: begin
        res = dif[31:0];
        ca = dif[32];
        ov = (a[31] != opb[31]) && (dif[31] != a[31]);
      end
      fxu_pkg::fxu_op_and: res = a & opb;
      fxu_pkg::fxu_op_or: res = a | opb;
      fxu_pkg::fxu_op_xor: res = a ^ opb;
      fxu_pkg::fxu_op_nor: res = ~(a | opb);
      default: res = sum[31:0];
    endcase
  end

  // storage access decode
  logic is_ld;
  logic is_mem;
  logic is_str;
  logic len0;
  logic inval;
  logic mis;
  logic trap_hit;
  logic [31:0] ea;
  fxu_pkg::fxu_size_t sz;
  assign is_ld = iss.op == fxu_pkg::fxu_op_load || iss.op == fxu_pkg::fxu_op_lstrx;
  assign is_str = iss.op == fxu_pkg::fxu_op_lstrx || iss.op == fxu_pkg::fxu_op_ststrx;
  assign is_mem = is_ld || iss.op == fxu_pkg::fxu_op_store ||
    iss.op == fxu_pkg::fxu_op_ststrx;
  assign len0 = is_str && xer_q[`FXU_XER_LEN] == 7'h00;
  assign ea = ((ra == `FXU_GPR0 && !iss.update) ? `FXU_WORD_RST : a) + opb;
  assign sz = is_str ? fxu_pkg::fxu_sz_word : iss.size;
  assign mis = misal(ea[1:0], sz) && !hwua;
  assign inval = (is_mem && !old && iss.update && (ra == `FXU_GPR0 || ra == rt)) ||
    (!old && (iss.op == fxu_pkg::fxu_op_mtmq || iss.op == fxu_pkg::fxu_op_mfmq));
  assign trap_hit = |(iss.instr[`FXU_F_TO] & cnd);
  assign so_now = xer_q[`FXU_XER_SO] | (arith & ov);

  // completion of an outstanding access
  logic fin;
  logic fin_ok;
  logic op_ld;
  logic wb_base;
  logic [4:0] rt_q;
  logic [4:0] ra_q;
  logic [31:0] ld_data;
  assign fin = ce && st_q == fxu_pkg::fxu_st_mem && mem_ack;
  assign fin_ok = fin && !mem_fault;
  assign rt_q = op_q.instr[`FXU_F_RT];
  assign ra_q = op_q.instr[`FXU_F_RA];
  assign op_ld = op_q.op == fxu_pkg::fxu_op_load || op_q.op == fxu_pkg::fxu_op_lstrx;
  assign wb_base = op_q.update && ra_q != `FXU_GPR0 && !(op_ld && ra_q == rt_q);

  always_comb begin
    case (mem_q.size)
      fxu_pkg::fxu_sz_byte: ld_data = {24'h00_0000, mem_rdata[7:0]};
      fxu_pkg::fxu_sz_half: ld_data = {16'h0000, mem_rdata[15:0]};
      default: ld_data = mem_rdata;
    endcase
  end

  // apb decode
  logic setup;
  logic acc;
  logic wr;
  logic gwin;
  assign setup = psel & ~penable;
  assign acc = psel & penable & pready;
  assign wr = acc & pwrite & ~err_q;
  assign gwin = paddr[`FXU_GPR_WIN_HI] == `FXU_GPR_WIN;
  assign pready = ce & penable & ack_q;
  assign pslverr = pready & err_q;
  assign prdata = prdata_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
      prdata_q <= `FXU_WORD_RST;
    end else if (ce) begin
      if (setup) begin
        ack_q <= 1'b1;
        err_q <= 1'b0;
        prdata_q <= `FXU_WORD_RST;
        if (paddr[1:0] != 2'b00) begin
          err_q <= 1'b1;
        end else if (gwin) begin
          prdata_q <= gpr_q[paddr[`FXU_GPR_IDX]];
        end else begin
          case (paddr)
            `FXU_OFF_CTRL: prdata_q <= ctrl_q;
            `FXU_OFF_XER: prdata_q <= xer_q;
            `FXU_OFF_MQ: prdata_q <= old ? mq_q : `FXU_WORD_RST;
            `FXU_OFF_CR: prdata_q <= cr_q;
            `FXU_OFF_STAT: prdata_q <= {30'h0000_0000, mem_req_q, ~iss_ready};
            default: err_q <= 1'b1;
          endcase
        end
      end else if (acc) begin
        ack_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `FXU_CTRL_RST;
    end else if (ce && wr && paddr == `FXU_OFF_CTRL) begin
      ctrl_q <= pwdata & `FXU_CTRL_MASK;
    end
  end

  // general registers; execution writes win over software on the same index
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 32; i++) begin
        gpr_q[i] <= `FXU_WORD_RST;
      end
    end else if (ce) begin
      if (wr && gwin) begin
        gpr_q[paddr[`FXU_GPR_IDX]] <= pwdata;
      end
      if (fire && !inval && alu_op) begin
        gpr_q[rt] <= res;
      end
      if (fire && !inval && iss.op == fxu_pkg::fxu_op_mfmq) begin
        gpr_q[rt] <= mq_q;
      end
      if (fin_ok && wb_base) begin
        gpr_q[ra_q] <= mem_q.addr;
      end
      if (fin_ok && op_ld) begin
        gpr_q[rt_q] <= ld_data;
      end
    end
  end

  // exception register: hardware set of summary overflow beats a software clear
  logic so_base;
  assign so_base = (wr && paddr == `FXU_OFF_XER) ? pwdata[`FXU_XER_SO] :
    xer_q[`FXU_XER_SO];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xer_q <= `FXU_WORD_RST;
    end else if (ce) begin
      if (wr && paddr == `FXU_OFF_XER) begin
        xer_q <= pwdata;
      end
      if (fire && !inval && arith) begin
        xer_q[`FXU_XER_CA] <= ca;
        xer_q[`FXU_XER_OV] <= ov;
        xer_q[`FXU_XER_SO] <= so_base | ov;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mq_q <= `FXU_WORD_RST;
    end else if (ce) begin
      if (wr && paddr == `FXU_OFF_MQ) begin
        mq_q <= pwdata;
      end
      if (fire && !inval && iss.op == fxu_pkg::fxu_op_mtmq) begin
        mq_q <= s;
      end
    end
  end

  // condition register
  assign cr = cr_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cr_q <= `FXU_WORD_RST;
    end else if (ce && fire && !inval) begin
      if (alu_op && iss.instr[`FXU_F_RC]) begin
        cr_q <= crput(cr_q, `FXU_CR0, {res[31], !res[31] && res != 32'h0000_0000,
          res == 32'h0000_0000, so_now});
      end else if (iss.op == fxu_pkg::fxu_op_cmp) begin
        cr_q <= crput(cr_q, iss.instr[`FXU_F_BF], {cnd[4:2], so_now});
      end else if (iss.op == fxu_pkg::fxu_op_cmpl) begin
        cr_q <= crput(cr_q, iss.instr[`FXU_F_BF], {cnd[1:0], cnd[2], so_now});
      end
    end
  end

  // storage request and sequencing
  assign mem_req = mem_req_q;
  assign mem = mem_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= fxu_pkg::fxu_st_idle;
      mem_req_q <= 1'b0;
      mem_q <= '0;
      op_q <= '0;
    end else if (ce) begin
      case (st_q)
        fxu_pkg::fxu_st_idle: begin
          if (fire && is_mem && !inval && !mis && !len0) begin
            st_q <= fxu_pkg::fxu_st_mem;
            mem_req_q <= 1'b1;
            op_q <= iss;
            mem_q.addr <= ea;
            mem_q.wdata <= s;
            mem_q.we <= !is_ld;
            mem_q.size <= sz;
          end
        end
        fxu_pkg::fxu_st_mem: begin
          if (mem_ack) begin
            st_q <= fxu_pkg::fxu_st_idle;
            mem_req_q <= 1'b0;
          end
        end
        default: st_q <= fxu_pkg::fxu_st_idle;
      endcase
    end
  end

  // one-cycle event pulses
  assign evt = evt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_q <= '0;
    end else if (ce) begin
      evt_q <= '0;
      if (fire) begin
        evt_q.tag <= iss.tag;
        evt_q.invalid <= inval;
        evt_q.trap <= !inval && iss.op == fxu_pkg::fxu_op_trap && trap_hit;
        evt_q.sc <= !inval && iss.op == fxu_pkg::fxu_op_sc;
        evt_q.align <= !inval && is_mem && mis && !len0;
        evt_q.done <= inval || !is_mem || mis || len0;
      end else if (fin) begin
        evt_q.tag <= op_q.tag;
        evt_q.dsi <= mem_fault;
        evt_q.done <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_trap;
    fire && !inval && iss.op == fxu_pkg::fxu_op_trap |=> evt.trap == $past(trap_hit);
  endproperty
  a_trap: assert property (p_trap) else $error("trap outcome wrong");

  property p_trap_lt;
    fire && !inval && iss.op == fxu_pkg::fxu_op_trap && iss.instr[25] &&
      $signed(a) < $signed(opb) |=> evt.trap;
  endproperty
  a_trap_lt: assert property (p_trap_lt) else $error("lt trap missed");

  property p_add;
    fire && !inval && iss.op == fxu_pkg::fxu_op_add && !(wr && gwin) |=>
      gpr_q[$past(rt)] == $past(a) + $past(opb);
  endproperty
  a_add: assert property (p_add) else $error("add result wrong");

  property p_align;
    fire && is_mem && !inval && mis && !len0 |=> evt.align && !mem_req ##1 !mem_req;
  endproperty
  a_align: assert property (p_align) else $error("alignment not raised");

  property p_sc;
    fire && !inval && iss.op == fxu_pkg::fxu_op_sc |=> evt.sc && evt.done;
  endproperty
  a_sc: assert property (p_sc) else $error("system call not raised");

  property p_fault;
    fin && mem_fault && !(wr && gwin) |=> evt.dsi &&
      gpr_q[$past(ra_q)] == $past(gpr_q[ra_q]) && gpr_q[$past(rt_q)] == $past(gpr_q[rt_q]);
  endproperty
  a_fault: assert property (p_fault) else $error("faulted access wrote registers");

  property p_load;
    fin_ok && op_ld |=> gpr_q[$past(rt_q)] == $past(ld_data);
  endproperty
  a_load: assert property (p_load) else $error("load data not written");

  property p_len0;
    fire && len0 && !inval && !(wr && gwin) |=> gpr_q[$past(rt)] == $past(s) && !mem_req;
  endproperty
  a_len0: assert property (p_len0) else $error("zero-length string changed target");

  property p_inval;
    fire && is_mem && !old && iss.update && ra == `FXU_GPR0 |=> evt.invalid && !mem_req;
  endproperty
  a_inval: assert property (p_inval) else $error("invalid form accepted");
endmodule

/* File: hw/fxu_pkg.sv */
package fxu_pkg;
  typedef enum logic [4:0] {
    fxu_op_add, fxu_op_sub, fxu_op_and, fxu_op_or, fxu_op_xor, fxu_op_nor,
    fxu_op_cmp, fxu_op_cmpl, fxu_op_trap, fxu_op_load, fxu_op_store,
    fxu_op_lstrx, fxu_op_ststrx, fxu_op_sc, fxu_op_mtmq, fxu_op_mfmq
  } fxu_op_t;
  typedef enum logic [1:0] {fxu_src_reg, fxu_src_si, fxu_src_ui} fxu_src_t;
  typedef enum logic [1:0] {fxu_sz_byte, fxu_sz_half, fxu_sz_word} fxu_size_t;
  typedef enum logic {fxu_st_idle, fxu_st_mem} fxu_state_t;
  typedef struct packed {
    fxu_op_t op;
    logic [31:0] instr;
    fxu_src_t src;
    logic update;
    fxu_size_t size;
    logic [7:0] tag;
  } fxu_issue_t;
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic we;
    fxu_size_t size;
  } fxu_mreq_t;
  typedef struct packed {
    logic trap;
    logic align;
    logic dsi;
    logic sc;
    logic invalid;
    logic done;
    logic [7:0] tag;
  } fxu_evt_t;
endpackage

/* File: tb/fxu_exec_tb.sv */
`timescale 1ns/1ns
module fxu_exec_tb;
  localparam logic [31:0] A = 32'hf0f0_cc33;
  localparam logic [31:0] B = 32'h0ff0_aa55;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic iss_valid, iss_ready, mem_req, mem_ack, mem_fault, slow, ce;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, mem_rdata, cr;
  logic [31:0] lx [4];
  logic [7:0] tg;
  fxu_pkg::fxu_issue_t iss;
  fxu_pkg::fxu_mreq_t mem;
  fxu_pkg::fxu_evt_t evt, ev;
  int miscompares, comparisons;
  fxu_exec uut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .iss_valid(iss_valid), .iss(iss), .iss_ready(iss_ready),
    .mem_req(mem_req), .mem(mem), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .mem_fault(mem_fault), .evt(evt), .cr(cr));
  fxu_mem_model mdl (.pclk(pclk), .presetn(presetn), .slow(slow), .mem_req(mem_req),
    .mem(mem), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .mem_fault(mem_fault));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic stop_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // check pready at each access edge; take prdata and pslverr at the edge where pready is seen high
    for (int i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
      if (i == 19) miscompares++;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [31:0] f(input logic [4:0] t, input logic [4:0] a,
    input logic [15:0] i);
    return {6'h00, t, a, i};
  endfunction
  task automatic g(input logic [4:0] n, input logic [31:0] v);
    apb(1'b1, 12'h080 + {5'h00, n, 2'b00}, v);
  endtask
  task automatic cg(input logic [4:0] n, input logic [31:0] e);
    apb(1'b0, 12'h080 + {5'h00, n, 2'b00}, 32'h0);
    chk(rd, e);
  endtask
  // op: 0 add 2..5 logic 6 cmp 7 cmpl 8 trap 9 load 10 store 11 string load 13 sc
  // src: 0 register 1 signed 2 unsigned; size: 0 byte 1 half 2 word
  task automatic ex(input logic [4:0] op, input logic [31:0] ins, input logic [1:0] s,
    input logic u, input logic [1:0] z);
    @(posedge pclk);
    tg = tg + 8'h01;
    iss_valid <= 1'b1;
    iss <= '{op: fxu_pkg::fxu_op_t'(op), instr: ins, src: fxu_pkg::fxu_src_t'(s),
      update: u, size: fxu_pkg::fxu_size_t'(z), tag: tg};
    @(posedge pclk);
    iss_valid <= 1'b0;
    #1;
    for (int i = 0; i < 40 && evt.done !== 1'b1; i++) begin
      @(posedge pclk);
      #1;
    end
    ev = evt;
    chk(32'(ev.tag), 32'(tg));
  endtask
  task automatic cmpc(input logic [4:0] op, input logic [1:0] s, input logic [15:0] i,
    input logic [31:0] e);
    ex(op, f(5'd0, 5'd8, i), s, 1'b0, 2'd2);
    chk(32'(cr[31:29]), e);
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    iss_valid = 1'b0;
    iss = '0;
    slow = 1'b0;
    ce = 1'b1;
    tg = 8'h00;
    miscompares = 0;
    comparisons = 0;
    lx = '{A & B, A | B, A ^ B, ~(A | B)};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a < 16; a += 4) begin
      apb(1'b0, 12'(a), 32'h0);
      chk(rd, 32'h0);
    end
    apb(1'b0, 12'h044, 32'h0);
    chk(32'(er), 32'h1);
    for (int n = 0; n < 32; n++) g(5'(n), 32'h5a00_0000 + n * 32'h0001_0203);
    for (int n = 0; n < 32; n++) cg(5'(n), 32'h5a00_0000 + n * 32'h0001_0203);
    g(5'd0, 32'h0);
    apb(1'b1, 12'h004, 32'h0000_0004);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h0000_0004);
    g(5'd1, 32'hffff_fffb);
    g(5'd2, 32'h3);
    ex(5'd0, f(5'd3, 5'd1, 16'h1001), 2'd0, 1'b0, 2'd2);
    cg(5'd3, 32'hffff_fffe);
    chk(32'(cr[31:29]), 32'h4);
    ex(5'd0, f(5'd4, 5'd1, 16'h8000), 2'd1, 1'b0, 2'd2);
    cg(5'd4, 32'hffff_7ffb);
    // clock enable low: an offered add must not be taken
    @(posedge pclk);
    ce <= 1'b0;
    iss_valid <= 1'b1;
    iss <= '{op: fxu_pkg::fxu_op_add, instr: f(5'd3, 5'd1, 16'h0000),
      src: fxu_pkg::fxu_src_reg, update: 1'b0, size: fxu_pkg::fxu_sz_word, tag: 8'hff};
    repeat (3) @(posedge pclk);
    #1;
    chk(32'(evt.done), 32'h0);
    chk(32'(iss_ready), 32'h1);
    @(posedge pclk);
    iss_valid <= 1'b0;
    ce <= 1'b1;
    cg(5'd3, 32'hffff_fffe);
    g(5'd5, A);
    g(5'd6, B);
    for (int k = 0; k < 4; k++) begin
      ex(5'(k + 2), f(5'd7, 5'd5, 16'h3000), 2'd0, 1'b0, 2'd2);
      cg(5'd7, lx[k]);
    end
    g(5'd8, 32'hffff_ffff);
    g(5'd9, 32'h1);
    cmpc(5'd6, 2'd0, 16'h4800, 32'h4);
    cmpc(5'd7, 2'd0, 16'h4800, 32'h2);
    cmpc(5'd6, 2'd1, 16'hffff, 32'h1);
    cmpc(5'd7, 2'd2, 16'hffff, 32'h2);
    for (int k = 0; k < 5; k++) begin
      ex(5'd8, f(5'b10000 >> k, 5'd8, 16'h4800), 2'd0, 1'b0, 2'd2);
      chk(32'(ev.trap), 32'((5'b10001 >> k) & 5'b00001));
    end
    ex(5'd8, f(5'b11011, 5'd8, 16'hffff), 2'd1, 1'b0, 2'd2);
    chk(32'(ev.trap), 32'h0);
    ex(5'd8, f(5'b00100, 5'd8, 16'hffff), 2'd1, 1'b0, 2'd2);
    chk(32'(ev.trap), 32'h1);
    ex(5'd13, 32'h0, 2'd0, 1'b0, 2'd2);
    chk(32'(ev.sc), 32'h1);
    g(5'd10, 32'h40);
    g(5'd11, 32'hdead_beef);
    slow <= 1'b1;
    ex(5'd10, f(5'd11, 5'd10, 16'h0), 2'd1, 1'b0, 2'd2);
    ex(5'd9, f(5'd12, 5'd10, 16'h0), 2'd1, 1'b0, 2'd2);
    cg(5'd12, 32'hdead_beef);
    slow <= 1'b0;
    ex(5'd9, f(5'd12, 5'd10, 16'h1), 2'd1, 1'b0, 2'd0);
    cg(5'd12, 32'h0000_00ad);
    ex(5'd10, f(5'd11, 5'd10, 16'h2), 2'd1, 1'b0, 2'd0);
    ex(5'd9, f(5'd12, 5'd10, 16'h0), 2'd1, 1'b0, 2'd2);
    cg(5'd12, 32'hdead_efef);
    ex(5'd9, f(5'd12, 5'd10, 16'h1), 2'd1, 1'b0, 2'd2);
    chk(32'(ev.align), 32'h1);
    cg(5'd12, 32'hdead_efef);
    apb(1'b1, 12'h000, 32'h2);
    ex(5'd9, f(5'd12, 5'd10, 16'h1), 2'd1, 1'b0, 2'd2);
    chk(32'(ev.align), 32'h0);
    cg(5'd12, 32'hadef_ef00);
    ex(5'd9, f(5'd10, 5'd10, 16'h0), 2'd1, 1'b1, 2'd2);
    chk(32'(ev.invalid), 32'h1);
    ex(5'd10, f(5'd11, 5'd0, 16'h0), 2'd1, 1'b1, 2'd2);
    chk(32'(ev.invalid), 32'h1);
    ex(5'd9, f(5'd12, 5'd10, 16'h4), 2'd1, 1'b1, 2'd2);
    cg(5'd10, 32'h44);
    apb(1'b1, 12'h000, 32'h3);
    ex(5'd9, f(5'd10, 5'd10, 16'hfffc), 2'd1, 1'b1, 2'd2);
    cg(5'd10, 32'hdead_efef);
    ex(5'd10, f(5'd11, 5'd0, 16'h48), 2'd1, 1'b1, 2'd2);
    cg(5'd0, 32'h0);
    g(5'd13, 32'h1000);
    ex(5'd9, f(5'd12, 5'd13, 16'h4), 2'd1, 1'b1, 2'd2);
    chk(32'(ev.dsi), 32'h1);
    cg(5'd13, 32'h1000);
    cg(5'd12, 32'h0);
    ex(5'd10, f(5'd11, 5'd13, 16'h4), 2'd1, 1'b1, 2'd2);
    cg(5'd13, 32'h1000);
    apb(1'b1, 12'h008, 32'h1357_9bdf);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h1357_9bdf);
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 12'h004, 32'h0);
    g(5'd10, 32'h40);
    g(5'd12, 32'h0bad_cafe);
    ex(5'd11, f(5'd12, 5'd10, 16'h0), 2'd0, 1'b0, 2'd2);
    cg(5'd12, 32'h0bad_cafe);
    apb(1'b1, 12'h004, 32'h4);
    ex(5'd11, f(5'd12, 5'd10, 16'h0), 2'd0, 1'b0, 2'd2);
    cg(5'd12, 32'hdead_efef);
    stop_test();
  end
  initial begin
    #300000;
    miscompares++;
    stop_test();
  end
endmodule

/* File: tb/fxu_mem_model.sv */
`timescale 1ns/1ns
module fxu_mem_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // answer pacing
  input wire logic slow,
  // storage port
  input wire logic mem_req,
  input wire fxu_pkg::fxu_mreq_t mem,
  output logic mem_ack,
  output logic [31:0] mem_rdata,
  output logic mem_fault
);
  logic [7:0] m [256];
  logic [1:0] cnt_q;
  logic [31:0] v;
  int n;
  initial for (int i = 0; i < 256; i++) m[i] = 8'h00;
  always_comb n = (mem.size == fxu_pkg::fxu_sz_byte) ? 1 :
                  (mem.size == fxu_pkg::fxu_sz_half) ? 2 : 4;
  // addresses with bit 12 set answer with a storage fault
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      cnt_q <= 2'h0;
      mem_rdata <= 32'h0;
      mem_fault <= 1'b0;
    end else if (mem_ack || !mem_req) begin
      // with no request pending, and in the cycle after an answer, the data and fault lines toggle; they hold while a slow request waits
      mem_ack <= 1'b0;
      mem_fault <= ~mem_fault;
      mem_rdata <= ~mem_rdata;
      cnt_q <= 2'h0;
    end else if (cnt_q < (slow ? 2'h3 : 2'h0)) begin
      cnt_q <= cnt_q + 2'h1;
    end else begin
      mem_ack <= 1'b1;
      mem_fault <= mem.addr[12];
      v = 32'h0;
      for (int i = 0; i < n; i++) begin
        v = {v[23:0], m[8'(mem.addr + i)]};
        if (mem.we && !mem.addr[12]) m[8'(mem.addr + i)] <= mem.wdata[8*(n-1-i) +: 8];
      end
      mem_rdata <= mem.we ? ~mem_rdata : v;
    end
  end
endmodule
